// ### design/ufc_top.sv
// UART register-set selection and enhanced feature control
`timescale 1ns/1ps
`default_nettype none
module ufc_top (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   input wire logic cts_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_char_i,
   input wire logic rx_push_i,
   input wire logic rx_pop_i,
   input wire logic tx_push_i,
   input wire logic tx_pop_i,
   input wire logic [7:0] rx_trigger_i,
   output logic rts_o,
   output logic tx_halt_o,
   output logic rx_level_hit_o,
   output logic [15:0] divisor_o,
   output logic [1:0] tx_flow_sel_o,
   output var ufc_pkg::ufc_enh_t enh_o
);
   import ufc_pkg::*;

   // ----------------------------------------
   // Pin synchronisers: a bit changes once stages two and three agree
   // ----------------------------------------
   logic [PIN_W-1:0] s1_q;
   logic [PIN_W-1:0] s2_q;
   logic [PIN_W-1:0] s3_q;
   logic [PIN_W-1:0] pin_q;
   logic [PIN_W-1:0] pin_d;
   wire [PIN_W-1:0] pin_raw = {cts_i, cs_n_i, rd_n_i, wr_n_i, addr_i, data_i};

   assign pin_d = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         pin_q <= '1;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end

   wire cts_f = pin_q[PIN_CTS];
   wire wr_act = !pin_q[PIN_CS] && !pin_q[PIN_WR];
   wire rd_act = !pin_q[PIN_CS] && !pin_q[PIN_RD];
   wire [2:0] adr = pin_q[10:8];
   wire [7:0] wdat = pin_q[7:0];

   logic wr_act_q;
   logic rd_act_q;
   wire wr_ev = wr_act && !wr_act_q;
   wire rd_ev = rd_act && !rd_act_q;

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [7:0] sel_q;
   logic [7:0] spr_q;
   logic [7:0] dll_q;
   logic [7:0] dlm_q;
   logic [7:0] ier_q;
   logic [7:0] fcr_q;
   logic [7:0] mcr_q;
   ufc_efr_t efr_q;
   ufc_chars_t chars_q;
   logic spec_q;
   logic rts_hold_q;
   logic flow_pause_q;
   logic [7:0] rdata_q;

   wire [1:0] set = sel_q[2:1];
   wire lvl_en = sel_q[SEL_CNT_EN] && (set == SET_GEN);
   wire in_gen = set == SET_GEN;
   wire in_first = set == SET_FIRST;
   wire in_second = set == SET_SECOND;

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   wire w_sel = wr_ev && adr == ADR_SEL;
   wire w_ier = wr_ev && in_gen && adr == ADR_IER;
   wire w_fcr = wr_ev && in_gen && adr == ADR_ISR;
   wire w_mcr = wr_ev && in_gen && adr == ADR_MCR;
   wire w_spr = wr_ev && in_gen && adr == ADR_SPR;
   wire w_dll = wr_ev && in_first && adr == ADR_DLL;
   wire w_dlm = wr_ev && in_first && adr == ADR_DLM;
   wire w_res1 = wr_ev && in_second && adr == ADR_RES1;
   wire w_res2 = wr_ev && in_second && adr == ADR_RES2;
   wire w_efr = wr_ev && in_second && adr == ADR_EFR;
   wire w_pau1 = wr_ev && in_second && adr == ADR_PAU1;
   wire w_pau2 = wr_ev && in_second && adr == ADR_PAU2;
   wire r_isr = rd_ev && in_gen && adr == ADR_ISR;

   // Enhanced bits take writes only while enhanced bit 4 is set, else they stay latched
   wire enh_wr = efr_q.enh_en;
   wire [7:0] ier_d = enh_wr ? wdat : {ier_q[7:4], wdat[3:0]};
   wire [7:0] fcr_d = enh_wr ? wdat : {fcr_q[7:6], fcr_q[5:4], wdat[3:0]} & {2'h0, 2'h3, ENH_MASK};
   wire [7:0] mcr_d = enh_wr ? wdat : {mcr_q[7:5], wdat[4:0]};

   // ----------------------------------------
   // Level counters and character matching
   // ----------------------------------------
   logic [CNT_W-1:0] rx_fill;
   logic [CNT_W-1:0] tx_fill;
   logic resume_ev;
   logic pause_ev;
   wire [CNT_W-1:0] tx_space = CNT_W'(FIFO_DEPTH) - tx_fill;

   ufc_level_count u_rx_cnt (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .push_i(rx_push_i),
      .pop_i(rx_pop_i),
      .fill_o(rx_fill)
   );

   ufc_level_count u_tx_cnt (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .push_i(tx_push_i),
      .pop_i(tx_pop_i),
      .fill_o(tx_fill)
   );

   ufc_char_match u_match (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .rx_valid_i(rx_valid_i),
      .rx_char_i(rx_char_i),
      .rx_sel_i(efr_q.rx_sel),
      .both_tx_i(efr_q.tx_sel == FLOW_BOTH),
      .chars_i(chars_q),
      .resume_o(resume_ev),
      .pause_o(pause_ev)
   );

   // ----------------------------------------
   // Flow control decisions
   // ----------------------------------------
   wire spec_hit = efr_q.spec_det && rx_valid_i && (rx_char_i == chars_q.pau2);
   wire [8:0] trig_hi = {1'b0, rx_trigger_i} + 9'h001;
   wire [8:0] trig_lo = {1'b0, rx_trigger_i};
   wire rts_set = efr_q.auto_rts && ({1'b0, rx_fill} >= trig_hi);
   wire rts_clr = !efr_q.auto_rts || ({1'b0, rx_fill} < trig_lo);
   wire rts_d = efr_q.auto_rts ? rts_hold_q : !mcr_q[MCR_RTS];
   wire halt_d = (efr_q.auto_cts && cts_f) || flow_pause_q;
   wire enh_vis = efr_q.enh_en;
   wire [7:0] efr_rd = {efr_q.auto_cts, efr_q.auto_rts && rts_hold_q, efr_q.spec_det, efr_q.enh_en,
                        efr_q.tx_sel, efr_q.rx_sel};

   // ----------------------------------------
   // Read mux; the selector address has no read path
   // ----------------------------------------
   wire [7:0] gen_rd = (adr == ADR_IER) ? ier_q :
                       (adr == ADR_ISR) ? {3'h0, spec_q, 4'h0} :
                       (adr == ADR_TXCNT && lvl_en) ? tx_space :
                       (adr == ADR_MCR) ? mcr_q :
                       (adr == ADR_RXCNT && lvl_en) ? rx_fill :
                       (adr == ADR_SPR) ? spr_q : RST_BYTE;
   wire [7:0] first_rd = (adr == ADR_DLL) ? dll_q : (adr == ADR_DLM) ? dlm_q : RST_BYTE;
   wire [7:0] second_rd = (adr == ADR_RES1) ? chars_q.res1 :
                          (adr == ADR_RES2) ? chars_q.res2 :
                          (adr == ADR_EFR) ? efr_rd :
                          (adr == ADR_PAU1) ? chars_q.pau1 :
                          (adr == ADR_PAU2) ? chars_q.pau2 : RST_BYTE;
   wire [7:0] rd_mux = in_gen ? gen_rd : in_first ? first_rd : in_second ? second_rd : RST_BYTE;

   // ----------------------------------------
   // Bus edges and read data
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
         rdata_q <= RST_BYTE;
      end else begin
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
         rdata_q <= rd_ev ? rd_mux : rdata_q;
      end
   end

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel_q <= RST_BYTE;
         spr_q <= RST_BYTE;
         dll_q <= RST_BYTE;
         dlm_q <= RST_BYTE;
         ier_q <= RST_BYTE;
         fcr_q <= RST_BYTE;
         mcr_q <= RST_BYTE;
      end else begin
         if (w_sel) sel_q <= wdat & 8'h07;
         if (w_spr) spr_q <= wdat;
         if (w_dll) dll_q <= wdat;
         if (w_dlm) dlm_q <= wdat;
         if (w_ier) ier_q <= ier_d;
         if (w_fcr) fcr_q <= fcr_d;
         if (w_mcr) mcr_q <= mcr_d;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         efr_q <= '0;
         chars_q <= '0;
      end else begin
         if (w_efr) efr_q <= ufc_efr_t'(wdat);
         if (w_res1) chars_q.res1 <= wdat;
         if (w_res2) chars_q.res2 <= wdat;
         if (w_pau1) chars_q.pau1 <= wdat;
         if (w_pau2) chars_q.pau2 <= wdat;
      end
   end

   // Match flag: a hit in the cycle of a status read survives the clear
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         spec_q <= 1'b0;
         rts_hold_q <= 1'b0;
         flow_pause_q <= 1'b0;
      end else begin
         spec_q <= spec_hit || (spec_q && !r_isr);
         rts_hold_q <= rts_set || (rts_hold_q && !rts_clr);
         flow_pause_q <= (efr_q.rx_sel != FLOW_OFF) && (pause_ev || (flow_pause_q && !resume_ev));
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         data_o <= RST_BYTE;
         data_oe_o <= 1'b0;
         rts_o <= 1'b1;
         tx_halt_o <= 1'b0;
         rx_level_hit_o <= 1'b0;
         divisor_o <= '0;
         tx_flow_sel_o <= FLOW_OFF;
         enh_o <= '0;
      end else begin
         data_o <= rd_ev ? rd_mux : rdata_q;
         data_oe_o <= rd_act;
         rts_o <= rts_d;
         tx_halt_o <= halt_d;
         rx_level_hit_o <= efr_q.auto_rts && ({1'b0, rx_fill} >= trig_lo) && (rx_trigger_i != '0);
         divisor_o <= {dlm_q, dll_q};
         tx_flow_sel_o <= efr_q.tx_sel;
         enh_o <= enh_vis ? {ier_q[7:4], fcr_q[5:4], mcr_q[7:5]} : '0;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   lvl_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rd_ev && in_gen && (adr == ADR_TXCNT || adr == ADR_RXCNT) && !lvl_en |=> rdata_q == RST_BYTE)
      else $error("level count visible while gated");
   sel_hidden_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rd_ev && adr == ADR_SEL |=> data_o == RST_BYTE)
      else $error("selector returned on read");
   tx_space_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rd_ev && lvl_en && adr == ADR_TXCNT |=> rdata_q == CNT_W'(FIFO_DEPTH) - $past(tx_fill))
      else $error("transmit space count wrong");
   div_join_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      w_dlm ##1 1'b1 |=> divisor_o[15:8] == $past(wdat, 2))
      else $error("divisor high byte not joined");
   cts_halt_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      efr_q.auto_cts && cts_f |=> tx_halt_o)
      else $error("transmitter not halted by clear-to-send");
   rts_follow_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !efr_q.auto_rts |=> rts_o == !$past(mcr_q[MCR_RTS]))
      else $error("request-to-send ignores modem control");
   spec_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      spec_hit |=> spec_q [*1] ##1 (spec_q || $past(r_isr)))
      else $error("special character flag lost");
   enh_lock_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      w_ier && !efr_q.enh_en |=> $stable(ier_q[7:4]))
      else $error("enhanced bits written while latched");
   scratch_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      w_spr |=> spr_q == $past(wdat))
      else $error("scratch byte not stored");
   rts_hyst_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rts_set |=> ##1 rts_o)
      else $error("request-to-send not raised at level");
   rx_cnt_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rd_ev && lvl_en && adr == ADR_RXCNT |=> rdata_q == $past(rx_fill))
      else $error("receive fill count wrong");
   pause_halt_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      pause_ev && (efr_q.rx_sel != FLOW_OFF) |=> ##1 tx_halt_o)
      else $error("transmitter not paused by pause character");

   cov_lvl_c: cover property (@(posedge clk_i) disable iff (!nrst_i) rd_ev && lvl_en && adr == ADR_RXCNT);
   cov_spec_c: cover property (@(posedge clk_i) disable iff (!nrst_i) spec_hit);
   cov_rts_c: cover property (@(posedge clk_i) disable iff (!nrst_i) rts_hold_q ##[1:50] !rts_hold_q);
   cov_pause_c: cover property (@(posedge clk_i) disable iff (!nrst_i) flow_pause_q ##[1:50] !flow_pause_q);
   cov_halt_c: cover property (@(posedge clk_i) disable iff (!nrst_i) tx_halt_o ##1 !tx_halt_o);
endmodule
`default_nettype wire

// ### design/ufc_pkg.sv
// Package: constants, offsets and carrier types of the UART feature control block
package ufc_pkg;

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int unsigned FIFO_DEPTH = 128;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned PIN_W = 15;
   localparam int unsigned PIN_CTS = 14;
   localparam int unsigned PIN_CS = 13;
   localparam int unsigned PIN_RD = 12;
   localparam int unsigned PIN_WR = 11;

   // ----------------------------------------
   // Register set select codes (selector bits 2:1)
   // ----------------------------------------
   localparam logic [1:0] SET_GEN = 2'h0;
   localparam logic [1:0] SET_FIRST = 2'h1;
   localparam logic [1:0] SET_SECOND = 2'h2;

   // ----------------------------------------
   // Register offsets on the 3-bit address
   // ----------------------------------------
   localparam logic [2:0] ADR_SEL = 3'h6;
   localparam logic [2:0] ADR_IER = 3'h1;
   localparam logic [2:0] ADR_ISR = 3'h2;
   localparam logic [2:0] ADR_TXCNT = 3'h3;
   localparam logic [2:0] ADR_MCR = 3'h4;
   localparam logic [2:0] ADR_RXCNT = 3'h5;
   localparam logic [2:0] ADR_SPR = 3'h7;
   localparam logic [2:0] ADR_DLL = 3'h0;
   localparam logic [2:0] ADR_DLM = 3'h1;
   localparam logic [2:0] ADR_RES1 = 3'h0;
   localparam logic [2:0] ADR_RES2 = 3'h1;
   localparam logic [2:0] ADR_EFR = 3'h2;
   localparam logic [2:0] ADR_PAU1 = 3'h3;
   localparam logic [2:0] ADR_PAU2 = 3'h4;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int unsigned SEL_CNT_EN = 0;
   localparam int unsigned ISR_SPEC = 4;
   localparam int unsigned MCR_RTS = 1;
   localparam int unsigned EFR_AUTO_RTS = 6;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] ENH_MASK = 4'hF;

   // ----------------------------------------
   // Flow-control direction selection codes
   // ----------------------------------------
   localparam logic [1:0] FLOW_OFF = 2'h0;
   localparam logic [1:0] FLOW_SECOND = 2'h1;
   localparam logic [1:0] FLOW_FIRST = 2'h2;
   localparam logic [1:0] FLOW_BOTH = 2'h3;

   typedef struct packed {
      logic auto_cts;
      logic auto_rts;
      logic spec_det;
      logic enh_en;
      logic [1:0] tx_sel;
      logic [1:0] rx_sel;
   } ufc_efr_t;

   typedef struct packed {
      logic [3:0] ier_hi;
      logic [1:0] fcr_hi;
      logic [2:0] mcr_hi;
   } ufc_enh_t;

   typedef struct packed {
      logic [7:0] res1;
      logic [7:0] res2;
      logic [7:0] pau1;
      logic [7:0] pau2;
   } ufc_chars_t;

endpackage

// ### design/ufc_level_count.sv
// Occupancy counter of one FIFO, tracking pushes and pops every cycle
`timescale 1ns/1ps
`default_nettype none
module ufc_level_count (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic push_i,
   input wire logic pop_i,
   output logic [ufc_pkg::CNT_W-1:0] fill_o
);
   import ufc_pkg::*;

   localparam logic [CNT_W-1:0] FULL = CNT_W'(FIFO_DEPTH);
   localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

   logic [CNT_W-1:0] fill_q;
   logic [CNT_W-1:0] fill_d;
   wire do_push = push_i && !pop_i && (fill_q != FULL);
   wire do_pop = pop_i && !push_i && (fill_q != '0);

   assign fill_d = do_push ? fill_q + ONE : (do_pop ? fill_q - ONE : fill_q);
   assign fill_o = fill_q;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fill_q <= '0;
      end else begin
         fill_q <= fill_d;
      end
   end

   fill_bound_a: assert property (@(posedge clk_i) disable iff (!nrst_i) fill_q <= FULL)
      else $error("level count beyond FIFO depth");
endmodule
`default_nettype wire

// ### design/ufc_char_match.sv
// Receive-side comparison of incoming characters with the flow-control characters
`timescale 1ns/1ps
`default_nettype none
module ufc_char_match (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_char_i,
   input wire logic [1:0] rx_sel_i,
   input wire logic both_tx_i,
   input wire ufc_pkg::ufc_chars_t chars_i,
   output logic resume_o,
   output logic pause_o
);
   import ufc_pkg::*;

   logic [7:0] prev_q;
   logic prev_ok_q;

   // Bit 0 of each character register lines up with bit 0 of the received byte
   wire r1 = rx_char_i == chars_i.res1;
   wire r2 = rx_char_i == chars_i.res2;
   wire p1 = rx_char_i == chars_i.pau1;
   wire p2 = rx_char_i == chars_i.pau2;
   wire r_seq = prev_ok_q && (prev_q == chars_i.res1) && r2;
   wire p_seq = prev_ok_q && (prev_q == chars_i.pau1) && p2;
   wire dual = (rx_sel_i == FLOW_BOTH) && both_tx_i;
   wire either = (rx_sel_i == FLOW_BOTH) && !both_tx_i;

   assign resume_o = rx_valid_i && ((rx_sel_i == FLOW_FIRST && r1) || (rx_sel_i == FLOW_SECOND && r2) ||
                     (either && (r1 || r2)) || (dual && r_seq));
   assign pause_o = rx_valid_i && ((rx_sel_i == FLOW_FIRST && p1) || (rx_sel_i == FLOW_SECOND && p2) ||
                    (either && (p1 || p2)) || (dual && p_seq));

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_q <= RST_BYTE;
         prev_ok_q <= 1'b0;
      end else if (rx_valid_i) begin
         prev_q <= rx_char_i;
         prev_ok_q <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### test/ufc_host_model.sv
// Host processor model driving the parallel register bus pins
`timescale 1ns/1ps
`default_nettype none
module ufc_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdat_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic [2:0] addr_o,
   output logic [7:0] data_o
);
   initial begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      addr_o = 3'h0;
      data_o = 8'h00;
   end
   // Strobe held 7 clocks to clear the pin sync; idle lines show the inverse
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_i);
      #1;
      cs_n_o = 1'b0;
      rd_n_o = w;
      wr_n_o = !w;
      addr_o = a;
      data_o = d;
      repeat (7) @(posedge clk_i);
      q = rdat_i;
      #1;
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      addr_o = ~a;
      data_o = ~d;
      repeat (6) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ### test/ufc_top_tb.sv
// Self-checking bench of the UART feature control block
`timescale 1ns/1ps
`default_nettype none
module ufc_top_tb;
   import ufc_pkg::*;
   logic clk_i;
   logic nrst_i;
   logic cs_n, rd_n, wr_n, oe, cts, rxv, rts, halt, hit;
   logic [2:0] addr;
   logic [7:0] wdat, rdat, rxc, trig, q;
   logic [3:0] fev;
   logic [15:0] div;
   logic [1:0] txs;
   ufc_enh_t enh;
   int err_total;
   int tests_run;
   ufc_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
      .addr_i(addr), .data_i(wdat), .data_o(rdat), .data_oe_o(oe), .cts_i(cts), .rx_valid_i(rxv),
      .rx_char_i(rxc), .rx_push_i(fev[3]), .rx_pop_i(fev[2]), .tx_push_i(fev[1]), .tx_pop_i(fev[0]),
      .rx_trigger_i(trig), .rts_o(rts), .tx_halt_o(halt), .rx_level_hit_o(hit), .divisor_o(div),
      .tx_flow_sel_o(txs), .enh_o(enh));
   ufc_host_model i_host (.clk_i(clk_i), .rdat_i(rdat), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
      .addr_o(addr), .data_o(wdat));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      i_host.acc(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [2:0] a);
      i_host.acc(1'b0, a, 8'h00, q);
   endtask
   task automatic ev(input logic [3:0] m, input int n);
      repeat (n) begin
         @(posedge clk_i);
         #1;
         fev = m;
         @(posedge clk_i);
         #1;
         fev = 4'h0;
      end
   endtask
   task automatic rx(input logic [7:0] c);
      @(posedge clk_i);
      #1;
      rxv = 1'b1;
      rxc = c;
      @(posedge clk_i);
      #1;
      rxv = 1'b0;
      rxc = ~c;
   endtask
   task automatic t_reset();
      wr(ADR_SEL, 8'h04);
      rd(ADR_EFR);
      chk("efr", 16'h0000, {8'h00, q});
      chk("txsel", 16'h0000, {14'h0, txs});
      for (int i = 0; i < 4; i++) begin
         wr(ADR_EFR, {4'h1, i[1:0], 2'h0});
         chk("txsel", i[15:0], {14'h0, txs});
      end
   endtask
   task automatic t_scratch();
      wr(ADR_SEL, 8'h00);
      wr(ADR_SPR, 8'hA5);
      fork
         rd(ADR_SPR);
         begin
            repeat (6) @(posedge clk_i);
            #1;
            chk("oe", 16'h0001, {15'h0, oe});
         end
      join
      chk("oe", 16'h0000, {15'h0, oe});
      chk("spr", 16'h00A5, {8'h00, q});
      rd(ADR_SEL);
      chk("sel", 16'h0000, {8'h00, q});
   endtask
   task automatic t_div();
      wr(ADR_SEL, 8'h02);
      wr(ADR_DLL, 8'h34);
      wr(ADR_DLM, 8'h12);
      chk("div", 16'h1234, div);
      wr(ADR_SEL, 8'h06);
      wr(ADR_DLL, 8'hFF);
      chk("div", 16'h1234, div);
      wr(ADR_SEL, 8'h02);
      rd(ADR_DLM);
      chk("dlm", 16'h0012, {8'h00, q});
   endtask
   task automatic t_count();
      ev(4'h2, 3);
      ev(4'h8, 5);
      ev(4'h4, 1);
      wr(ADR_SEL, 8'h01);
      rd(ADR_TXCNT);
      chk("txcnt", 16'h007D, {8'h00, q});
      rd(ADR_RXCNT);
      chk("rxcnt", 16'h0004, {8'h00, q});
      wr(ADR_SEL, 8'h00);
      rd(ADR_RXCNT);
      chk("rxcnt", 16'h0000, {8'h00, q});
      wr(ADR_SEL, 8'h03);
      rd(ADR_RXCNT);
      chk("rxcnt", 16'h0000, {8'h00, q});
   endtask
   task automatic t_cts();
      wr(ADR_SEL, 8'h04);
      wr(ADR_EFR, 8'h80);
      #1;
      cts = 1'b1;
      repeat (8) @(posedge clk_i);
      chk("halt", 16'h0001, {15'h0, halt});
      #1;
      cts = 1'b0;
      repeat (8) @(posedge clk_i);
      chk("halt", 16'h0000, {15'h0, halt});
   endtask
   task automatic t_enh();
      wr(ADR_EFR, 8'h00);
      wr(ADR_SEL, 8'h00);
      wr(ADR_IER, 8'hF0);
      chk("enh", 16'h0000, {7'h0, enh});
      wr(ADR_SEL, 8'h04);
      wr(ADR_EFR, 8'h10);
      wr(ADR_SEL, 8'h00);
      wr(ADR_IER, 8'hF0);
      chk("ier", 16'h000F, {12'h0, enh.ier_hi});
      wr(ADR_SEL, 8'h04);
      wr(ADR_EFR, 8'h00);
      chk("enh", 16'h0000, {7'h0, enh});
      wr(ADR_EFR, 8'h10);
      chk("ier", 16'h000F, {12'h0, enh.ier_hi});
   endtask
   task automatic t_rts();
      wr(ADR_SEL, 8'h00);
      wr(ADR_MCR, 8'h02);
      chk("rts", 16'h0000, {15'h0, rts});
      wr(ADR_SEL, 8'h04);
      wr(ADR_EFR, 8'h50);
      ev(4'h8, 1);
      repeat (3) @(posedge clk_i);
      chk("rts", 16'h0001, {15'h0, rts});
      chk("hit", 16'h0001, {15'h0, hit});
      rd(ADR_EFR);
      chk("efr6", 16'h0001, {15'h0, q[6]});
      ev(4'h4, 1);
      repeat (3) @(posedge clk_i);
      chk("rts", 16'h0001, {15'h0, rts});
      chk("hit", 16'h0001, {15'h0, hit});
      ev(4'h4, 1);
      repeat (3) @(posedge clk_i);
      chk("hit", 16'h0000, {15'h0, hit});
      chk("rts", 16'h0000, {15'h0, rts});
   endtask
   task automatic t_spec();
      wr(ADR_EFR, 8'h30);
      wr(ADR_PAU2, 8'h13);
      wr(ADR_SEL, 8'h00);
      rx(8'h12);
      rd(ADR_ISR);
      chk("isr4", 16'h0000, {15'h0, q[ISR_SPEC]});
      rx(8'h13);
      rd(ADR_ISR);
      chk("isr4", 16'h0001, {15'h0, q[ISR_SPEC]});
   endtask
   task automatic rx_halt(input logic [7:0] c, input logic e);
      rx(c);
      repeat (2) @(posedge clk_i);
      chk("halt", {15'h0, e}, {15'h0, halt});
   endtask
   task automatic t_flow();
      wr(ADR_SEL, 8'h04);
      wr(ADR_RES1, 8'h11);
      wr(ADR_RES2, 8'h12);
      wr(ADR_PAU1, 8'h14);
      wr(ADR_EFR, 8'h12);
      rx_halt(8'h13, 1'b0);
      rx_halt(8'h14, 1'b1);
      rx_halt(8'h11, 1'b0);
      wr(ADR_EFR, 8'h1F);
      rx_halt(8'h14, 1'b0);
      rx_halt(8'h13, 1'b1);
      rx_halt(8'h12, 1'b1);
      rx_halt(8'h11, 1'b1);
      rx_halt(8'h12, 1'b0);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      wrap_up();
   end
   initial begin
      err_total = 0;
      tests_run = 0;
      nrst_i = 1'b0;
      cts = 1'b0;
      rxv = 1'b0;
      rxc = 8'h00;
      trig = 8'h04;
      fev = 4'h0;
      repeat (5) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      t_reset();
      t_scratch();
      t_div();
      t_count();
      t_cts();
      t_enh();
      t_rts();
      t_spec();
      t_flow();
      wrap_up();
   end
endmodule
`default_nettype wire
